// >>> hw/pmcb_cmd_bank.v
// Purpose: command register bank for soft-start timeout, turn-off timing,
//          status bytes, telemetry readback and output-voltage floor
// Assumes: a serial front end presents decoded command-port accesses
// Notes:   nonvolatile storage is outside; save/restore via the nv ports
//
// Overview of operation
// - soft-start timeout limit in ms, default 100; timeout fault if output stays below uv
// - programmable soft-start timeout response, default restart code, kept nonvolatile
// - programmable turn-off delay, default zero, applied before shutdown, kept nonvolatile
// - programmable soft-stop fall time, default zero, sets ramp-down length, nonvolatile
// - command 78h reads one byte of most critical fault summary
// - command 79h reads two bytes of fault and warning summary
// - command 7ah reads output voltage fault and warning byte
// - command 7bh reads output overcurrent fault and warning byte
// - command 7ch reads input fault status byte
// - command 7dh reads sensed temperature fault and warning byte
// - command 7eh reads bus communication fault byte
// - command 80h reads internal overtemperature and address detect fault byte
// - command 8bh reads measured output voltage
// - command 8ch reads measured output current
// - command 8eh reads temperature, fixed 25 c when detect disable is 0
// - command 98h reads fixed bus revision byte 12h
// - programmable floor, default 0.5 v, bounds setpoint from command or strap
// - programmable ceiling bounds setpoint from command or strap
// - voltage quantities are linear with exponent -9
`include "pmcb_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pmcb_cmd_bank (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        clk_en,
    // command port
    input  wire        cmd_valid,
    input  wire        cmd_write,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_wdata,
    output reg  [15:0] cmd_rdata,
    output reg         cmd_rvalid,
    output reg         cmd_error,
    // nonvolatile restore
    input  wire        nv_load,
    input  wire [7:0]  nv_ss_resp,
    input  wire [15:0] nv_off_delay,
    input  wire [15:0] nv_fall_time,
    output wire [7:0]  nv_ss_resp_out,
    output wire [15:0] nv_off_delay_out,
    output wire [15:0] nv_fall_time_out,
    // status and telemetry sources (same clock)
    input  wire [7:0]  crit_status,
    input  wire [7:0]  fw_status_hi,
    input  wire [7:0]  vout_status,
    input  wire [7:0]  iout_status,
    input  wire [7:0]  input_status,
    input  wire [7:0]  thermal_status,
    input  wire [7:0]  bus_comm_status,
    input  wire [7:0]  vendor_status,
    input  wire [15:0] vout_meas,
    input  wire [15:0] iout_meas,
    input  wire [15:0] temp_meas,
    input  wire        soft_start_detect_disable,
    // setpoint limiting
    input  wire [15:0] vout_command,
    input  wire [15:0] setpoint_strap_pin,
    input  wire        use_strap,
    input  wire [15:0] vout_ceiling,
    output reg  [15:0] setpoint_eff,
    output wire [4:0]  vout_exponent,
    // sequencing (pins from analog side, synchronised; turn_off_req taken as is)
    input  wire        soft_start_begin_pin,
    input  wire        above_uv_pin,
    output reg         ss_timeout_fault,
    input  wire        turn_off_req,
    output reg         ramp_down_start,
    output reg         ramp_down_done,
    output wire [15:0] fall_time_ms
);

// ==========================================================================
// registers
reg [15:0] ss_limit_reg;
reg [7:0]  ss_resp_reg;
reg [15:0] off_delay_reg;
reg [15:0] fall_reg;
reg [15:0] vout_floor_reg;

// ==========================================================================
// pin synchronisers, first stage read only by second stage
reg [1:0] ssb_sync_reg;
reg [1:0] uv_sync_reg;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ssb_sync_reg <= 2'b00;
        uv_sync_reg  <= 2'b00;
    end else if (clk_en) begin
        ssb_sync_reg <= {ssb_sync_reg[0], soft_start_begin_pin};
        uv_sync_reg  <= {uv_sync_reg[0], above_uv_pin};
    end
end
wire ss_begin = ssb_sync_reg[1];
wire above_uv = uv_sync_reg[1];

// ==========================================================================
// register writes; unknown or read-only codes flag an error
wire wr = clk_en && cmd_valid && cmd_write;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ss_limit_reg   <= `PMCB_RST_SS_TIMEOUT_LIMIT;
        ss_resp_reg    <= `PMCB_RST_SS_TIMEOUT_RESP;
        off_delay_reg  <= `PMCB_RST_TURN_OFF_DELAY;
        fall_reg       <= `PMCB_RST_SOFT_STOP_FALL;
        vout_floor_reg <= `PMCB_RST_VOUT_FLOOR;
    end else if (clk_en && nv_load) begin
        // restore wins over a bus write in the same cycle
        ss_resp_reg   <= nv_ss_resp;
        off_delay_reg <= nv_off_delay;
        fall_reg      <= nv_fall_time;
    end else if (wr) begin
        case (cmd_code)
            `PMCB_CMD_SS_TIMEOUT_LIMIT: ss_limit_reg   <= cmd_wdata;
            `PMCB_CMD_SS_TIMEOUT_RESP:  ss_resp_reg    <= cmd_wdata[7:0];
            `PMCB_CMD_TURN_OFF_DELAY:   off_delay_reg  <= cmd_wdata;
            `PMCB_CMD_SOFT_STOP_FALL:   fall_reg       <= cmd_wdata;
            `PMCB_CMD_VOUT_FLOOR:       vout_floor_reg <= cmd_wdata;
            default: ;
        endcase
    end
end
assign nv_ss_resp_out   = ss_resp_reg;
assign nv_off_delay_out = off_delay_reg;
assign nv_fall_time_out = fall_reg;
assign fall_time_ms     = fall_reg;
assign vout_exponent    = `PMCB_VOUT_EXPONENT;

// ==========================================================================
// read mux
reg [15:0] rd_next;
reg        hit_next;
reg        ro_next;
always @* begin
    rd_next  = 16'h0000;
    hit_next = 1'b1;
    ro_next  = 1'b1;
    case (cmd_code)
        `PMCB_CMD_SS_TIMEOUT_LIMIT:   begin rd_next = ss_limit_reg; ro_next = 1'b0; end
        `PMCB_CMD_SS_TIMEOUT_RESP:    begin rd_next = {8'h00, ss_resp_reg}; ro_next = 1'b0; end
        `PMCB_CMD_TURN_OFF_DELAY:     begin rd_next = off_delay_reg; ro_next = 1'b0; end
        `PMCB_CMD_SOFT_STOP_FALL:     begin rd_next = fall_reg; ro_next = 1'b0; end
        `PMCB_CMD_VOUT_FLOOR:         begin rd_next = vout_floor_reg; ro_next = 1'b0; end
        `PMCB_CMD_CRIT_SUMMARY:       rd_next = {8'h00, crit_status};
        `PMCB_CMD_FAULT_WARN_SUMMARY: rd_next = {fw_status_hi, crit_status};
        `PMCB_CMD_VOUT_STATUS:        rd_next = {8'h00, vout_status};
        `PMCB_CMD_IOUT_STATUS:        rd_next = {8'h00, iout_status};
        `PMCB_CMD_INPUT_STATUS:       rd_next = {8'h00, input_status};
        `PMCB_CMD_THERMAL_STATUS:     rd_next = {8'h00, thermal_status};
        `PMCB_CMD_BUS_COMM_STATUS:    rd_next = {8'h00, bus_comm_status};
        `PMCB_CMD_VENDOR_STATUS:      rd_next = {8'h00, vendor_status};
        `PMCB_CMD_VOUT_READBACK:      rd_next = vout_meas;
        `PMCB_CMD_IOUT_READBACK:      rd_next = iout_meas;
        `PMCB_CMD_TEMP_READBACK:      rd_next = soft_start_detect_disable ?
                                                temp_meas : `PMCB_FIXED_TEMP;
        `PMCB_CMD_BUS_SPEC_REV:       rd_next = {8'h00, `PMCB_BUS_SPEC_REV_VAL};
        default:                      hit_next = 1'b0;
    endcase
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        cmd_rdata  <= 16'h0000;
        cmd_rvalid <= 1'b0;
        cmd_error  <= 1'b0;
    end else if (clk_en) begin
        cmd_rvalid <= cmd_valid && !cmd_write && hit_next;
        cmd_error  <= cmd_valid && (!hit_next || (cmd_write && ro_next));
        if (cmd_valid && !cmd_write && hit_next)
            cmd_rdata <= rd_next;
    end
end

// ==========================================================================
// setpoint clamp: floor first, then ceiling; if the two cross, the floor wins only for requests below it
// a crossed pair still yields a defined setpoint instead of a refused write
wire [15:0] sp_req = use_strap ? setpoint_strap_pin : vout_command;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        setpoint_eff <= 16'h0000;
    end else if (clk_en) begin
        if (sp_req < vout_floor_reg)
            setpoint_eff <= vout_floor_reg;
        else if (sp_req > vout_ceiling)
            setpoint_eff <= vout_ceiling;
        else
            setpoint_eff <= sp_req;
    end
end

// ==========================================================================
// millisecond tick shared by both timers
localparam [16:0] MS_CYC = 17'd100000;
reg [16:0] tick_cnt_reg;
wire       ms_tick = (tick_cnt_reg == MS_CYC - 17'd1);
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
        tick_cnt_reg <= 17'h00000;
    else if (clk_en)
        tick_cnt_reg <= ms_tick ? 17'h00000 : tick_cnt_reg + 17'd1;
end

// ==========================================================================
// soft-start timeout timer
reg        ss_run_reg;
reg        ss_begin_d_reg;
reg [15:0] ss_ms_reg;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ss_run_reg       <= 1'b0;
        ss_begin_d_reg   <= 1'b0;
        ss_ms_reg        <= 16'h0000;
        ss_timeout_fault <= 1'b0;
    end else if (clk_en) begin
        ss_begin_d_reg <= ss_begin;
        if (ss_begin && !ss_begin_d_reg) begin
            ss_run_reg       <= 1'b1;
            ss_ms_reg        <= 16'h0000;
            ss_timeout_fault <= 1'b0;
        end else if (ss_run_reg) begin
            if (above_uv) begin
                ss_run_reg <= 1'b0;
            end else if (ss_limit_reg != 16'h0000 && ss_ms_reg >= ss_limit_reg) begin
                // a zero limit disables the timeout
                ss_run_reg       <= 1'b0;
                ss_timeout_fault <= 1'b1;
            end else if (ms_tick) begin
                ss_ms_reg <= ss_ms_reg + 16'd1;
            end
        end
    end
end

// ==========================================================================
// turn-off sequence: delay, then ramp for the fall time
localparam [2:0] ST_IDLE  = 3'b001;
localparam [2:0] ST_DELAY = 3'b010;
localparam [2:0] ST_FALL  = 3'b100;
reg [2:0]  off_st_reg;
reg [15:0] off_ms_reg;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        off_st_reg      <= ST_IDLE;
        off_ms_reg      <= 16'h0000;
        ramp_down_start <= 1'b0;
        ramp_down_done  <= 1'b0;
    end else if (clk_en) begin
        ramp_down_start <= 1'b0;
        ramp_down_done  <= 1'b0;
        case (off_st_reg)
            ST_IDLE: begin
                off_ms_reg <= 16'h0000;
                if (turn_off_req)
                    off_st_reg <= ST_DELAY;
            end
            ST_DELAY: begin
                if (off_ms_reg >= off_delay_reg) begin
                    off_st_reg      <= ST_FALL;
                    off_ms_reg      <= 16'h0000;
                    ramp_down_start <= 1'b1;
                end else if (ms_tick) begin
                    off_ms_reg <= off_ms_reg + 16'd1;
                end
            end
            ST_FALL: begin
                if (off_ms_reg >= fall_reg) begin
                    off_st_reg     <= ST_IDLE;
                    ramp_down_done <= 1'b1;
                end else if (ms_tick) begin
                    off_ms_reg <= off_ms_reg + 16'd1;
                end
            end
            default: off_st_reg <= ST_IDLE;
        endcase
    end
end

endmodule // pmcb_cmd_bank

`default_nettype wire

// >>> hw/pmcb_defines.vh
// Purpose: constants for the status, timing and limit command bank
// Assumes: command codes are the register addresses on the command port
// Notes:   reset values are the factory defaults of each command
`ifndef PMCB_DEFINES_VH
`define PMCB_DEFINES_VH

// ==========================================================================
// command codes
`define PMCB_CMD_SS_TIMEOUT_LIMIT   8'h62
`define PMCB_CMD_SS_TIMEOUT_RESP    8'h63
`define PMCB_CMD_TURN_OFF_DELAY     8'h64
`define PMCB_CMD_SOFT_STOP_FALL     8'h65
`define PMCB_CMD_CRIT_SUMMARY       8'h78
`define PMCB_CMD_FAULT_WARN_SUMMARY 8'h79
`define PMCB_CMD_VOUT_STATUS        8'h7a
`define PMCB_CMD_IOUT_STATUS        8'h7b
`define PMCB_CMD_INPUT_STATUS       8'h7c
`define PMCB_CMD_THERMAL_STATUS     8'h7d
`define PMCB_CMD_BUS_COMM_STATUS    8'h7e
`define PMCB_CMD_VENDOR_STATUS      8'h80
`define PMCB_CMD_VOUT_READBACK      8'h8b
`define PMCB_CMD_IOUT_READBACK      8'h8c
`define PMCB_CMD_TEMP_READBACK      8'h8e
`define PMCB_CMD_BUS_SPEC_REV       8'h98
`define PMCB_CMD_VOUT_FLOOR         8'ha4

// ==========================================================================
// reset values
`define PMCB_RST_SS_TIMEOUT_LIMIT   16'h0064
`define PMCB_RST_SS_TIMEOUT_RESP    8'hbf
`define PMCB_RST_TURN_OFF_DELAY     16'h0000
`define PMCB_RST_SOFT_STOP_FALL     16'h0000
`define PMCB_RST_VOUT_FLOOR         16'h0100
`define PMCB_FIXED_TEMP             16'h0019
`define PMCB_BUS_SPEC_REV_VAL       8'h12
`define PMCB_VOUT_EXPONENT          5'h17

// ==========================================================================
// timing: one millisecond tick
`define PMCB_CLK_HZ                 100000000
`define PMCB_MS_PER_TICK            1
`define PMCB_CYC_PER_MS             ((`PMCB_CLK_HZ / 1000) * `PMCB_MS_PER_TICK)

`endif

// >>> sim/pmcb_cmd_bank_chk.sv
// Purpose: port assertions for the command bank
// Assumes: one clock, rstn async active low
// Notes:   answers are checked one cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module pmcb_cmd_bank_chk (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_rvalid,
    input wire logic        cmd_error,
    input wire logic        nv_load,
    input wire logic [7:0]  nv_ss_resp,
    input wire logic [7:0]  nv_ss_resp_out,
    input wire logic [7:0]  crit_status,
    input wire logic [7:0]  fw_status_hi,
    input wire logic [15:0] vout_meas,
    input wire logic        soft_start_detect_disable,
    input wire logic [4:0]  vout_exponent
);
    // ==========================================================================
    // read answers, refusals and restore
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire rd_take = clk_en && cmd_valid && !cmd_write;
    rev_read_a: assert property (rd_take && cmd_code == 8'h98 |=>
        cmd_rvalid && cmd_rdata == 16'h0012) else $error("revision read wrong");
    crit_read_a: assert property (rd_take && cmd_code == 8'h78 |=>
        cmd_rdata == {8'h00, $past(crit_status)}) else $error("status byte wrong");
    word_read_a: assert property (rd_take && cmd_code == 8'h79 |=>
        cmd_rdata == $past({fw_status_hi, crit_status})) else $error("status word wrong");
    vout_read_a: assert property (rd_take && cmd_code == 8'h8b |=>
        cmd_rdata == $past(vout_meas)) else $error("voltage readback wrong");
    temp_fixed_a: assert property (rd_take && cmd_code == 8'h8e && !soft_start_detect_disable |=>
        cmd_rdata == 16'h0019) else $error("fixed temperature wrong");
    ro_write_a: assert property (clk_en && cmd_valid && cmd_write && cmd_code == 8'h7e |=>
        cmd_error && !cmd_rvalid) else $error("read-only write not refused");
    resp_restore_a: assert property (clk_en && nv_load |=>
        nv_ss_resp_out == $past(nv_ss_resp)) else $error("response restore wrong");
    exponent_a: assert property (vout_exponent == 5'h17)
        else $error("exponent wrong");
endmodule // pmcb_cmd_bank_chk
bind pmcb_cmd_bank pmcb_cmd_bank_chk i_pmcb_cmd_bank_chk (.*);
`default_nettype wire

// >>> sim/pmcb_host_model.sv
// Purpose: host side of the command port
// Assumes: one access at a time, launched just after a rising edge
// Notes:   idle lines carry inverted values so stale data cannot match
`timescale 1ns/1ps
`default_nettype none
module pmcb_host_model (
    input  wire logic        clk_sys,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_error
);
    // ==========================================================================
    // one access: request held for one taking edge, answer read in the next cycle
    initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0;
    task automatic access(input logic [7:0] c, input logic w, input logic [15:0] d,
                          output logic [15:0] r, output logic v, output logic e);
        @(posedge clk_sys);
        #1;
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'h1, w, c, d};
        @(posedge clk_sys);
        #1;
        {r, v, e} = {cmd_rdata, cmd_rvalid, cmd_error};
        {cmd_valid, cmd_code, cmd_wdata} = {1'h0, ~c, ~d};
    endtask
endmodule // pmcb_host_model
`default_nettype wire

// >>> sim/test_pmcb_cmd_bank.sv
// Purpose: self-checking bench for the command bank
// Assumes: pmcb_host_model owns the command port
// Notes:   ms timers cannot run out here, so only zero settings are timed
`timescale 1ns/1ps
`default_nettype none
module test_pmcb_cmd_bank;
    // ==========================================================================
    // stimulus and table
    typedef struct packed {logic [7:0] c; logic w; logic [15:0] x;} pmcb_row_t;
    logic        clk_sys = 1'h0, rstn = 1'h0, clk_en = 1'h1, nv_load = 1'h0, use_strap = 1'h0, rv, er;
    logic        soft_start_detect_disable = 1'h0, soft_start_begin_pin = 1'h0, above_uv_pin = 1'h0;
    logic        turn_off_req = 1'h0, cmd_valid, cmd_write, cmd_rvalid, cmd_error, ss_timeout_fault;
    logic        ramp_down_start, ramp_down_done;
    logic [7:0]  cmd_code, nv_ss_resp_out, nv_ss_resp = 8'h3c, crit_status = 8'h81, fw_status_hi = 8'h42;
    logic [7:0]  vout_status = 8'h13, iout_status = 8'h24, input_status = 8'h35, thermal_status = 8'h46;
    logic [7:0]  bus_comm_status = 8'h57, vendor_status = 8'h68;
    logic [15:0] cmd_wdata, cmd_rdata, nv_off_delay_out, nv_fall_time_out, setpoint_eff, fall_time_ms, rd;
    logic [15:0] nv_off_delay = 16'h0, nv_fall_time = 16'h0, vout_meas = 16'h0123, iout_meas = 16'hf00a;
    logic [15:0] temp_meas = 16'h002d, vout_command = 16'h0080, setpoint_strap_pin = 16'h0250;
    logic [15:0] vout_ceiling = 16'h0300;
    logic [4:0]  vout_exponent;
    int          fail_count = 0, comparisons = 0, i, n;
    pmcb_row_t   rows [0:24] = '{
        '{8'h62,1'h0,16'h0064}, '{8'h63,1'h0,16'h00bf}, '{8'h64,1'h0,16'h0}, '{8'h65,1'h0,16'h0},
        '{8'ha4,1'h0,16'h0100}, '{8'h98,1'h0,16'h0012}, '{8'h78,1'h0,16'h0081}, '{8'h79,1'h0,16'h4281},
        '{8'h7a,1'h0,16'h0013}, '{8'h7b,1'h0,16'h0024}, '{8'h7c,1'h0,16'h0035}, '{8'h7d,1'h0,16'h0046},
        '{8'h7e,1'h0,16'h0057}, '{8'h80,1'h0,16'h0068}, '{8'h8b,1'h0,16'h0123}, '{8'h8c,1'h0,16'hf00a},
        '{8'h8e,1'h0,16'h0019}, '{8'h62,1'h1,16'h0}, '{8'h64,1'h1,16'h0abc}, '{8'h65,1'h1,16'h0012},
        '{8'ha4,1'h1,16'h0200}, '{8'h62,1'h0,16'h0}, '{8'h64,1'h0,16'h0abc}, '{8'h65,1'h0,16'h0012},
        '{8'ha4,1'h0,16'h0200}};
    pmcb_cmd_bank i_pmcb_cmd_bank (.*);
    pmcb_host_model i_pmcb_host_model (.*);
    // ==========================================================================
    // checking and sequence
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        settle(4);
        rstn = 1'h1;
        for (i = 0; i < 25; i++) begin
            i_pmcb_host_model.access(rows[i].c, rows[i].w, rows[i].x, rd, rv, er);
            check("error flag", {15'h0, er}, 16'h0);
            check("read valid", {15'h0, rv}, {15'h0, !rows[i].w});
            if (!rows[i].w)
                check("read data", rd, rows[i].x);
        end
        i_pmcb_host_model.access(8'h7e, 1'h1, 16'h00ff, rd, rv, er);
        check("read-only write", {15'h0, er}, 16'h1);
        i_pmcb_host_model.access(8'h00, 1'h0, 16'h0000, rd, rv, er);
        check("unknown code error", {14'h0, er, rv}, 16'h2);
        settle(1);
        clk_en = 1'h0;
        i_pmcb_host_model.access(8'h98, 1'h0, 16'h0000, rd, rv, er);
        check("frozen read valid", {15'h0, rv}, 16'h0);
        clk_en = 1'h1;
        $display("test table done");
        nv_load = 1'h1;
        settle(1);
        nv_load = 1'h0;
        check("nv response", {8'h0, nv_ss_resp_out}, 16'h003c);
        check("nv delay", nv_off_delay_out, 16'h0);
        check("nv fall", nv_fall_time_out, 16'h0);
        check("fall time", fall_time_ms, 16'h0);
        check("exponent", {11'h0, vout_exponent}, 16'h0017);
        check("floor clamp", setpoint_eff, 16'h0200);
        vout_command = 16'h0400;
        settle(3);
        check("ceiling clamp", setpoint_eff, 16'h0300);
        turn_off_req = 1'h1;
        soft_start_begin_pin = 1'h1;
        er = 1'h0;
        for (n = 0; n < 20 && ramp_down_done !== 1'h1; n++) begin
            settle(1);
            er = er | (ramp_down_start === 1'h1);
        end
        check("ramp start", {15'h0, er}, 16'h1);
        check("ramp done", {15'h0, ramp_down_done}, 16'h1);
        if (n == 20) report_and_stop;
        settle(20);
        check("timeout with zero limit", {15'h0, ss_timeout_fault}, 16'h0);
        $display("test outputs done");
        turn_off_req = 1'h0;
        rstn = 1'h0;
        settle(2);
        rstn = 1'h1;
        i_pmcb_host_model.access(8'h62, 1'h0, 16'h0000, rd, rv, er);
        check("limit after reset", rd, 16'h0064);
        i_pmcb_host_model.access(8'ha4, 1'h0, 16'h0000, rd, rv, er);
        check("floor after reset", rd, 16'h0100);
        check("fault after reset", {15'h0, ss_timeout_fault}, 16'h0);
        $display("test reset done");
        report_and_stop;
    end
endmodule // test_pmcb_cmd_bank
`default_nettype wire
